// ---- rtl/fsu_pkg.sv ----
// Shared encodings, field positions and reset values for the subtract and flag unit.
package fsu_pkg;

   // Instruction word layout: low half-word in bits 15..0, high half-word in 31..16.
   localparam int unsigned HALF_W        = 16;
   localparam int unsigned SEL_W         = 3;
   localparam int unsigned NUM_REGS      = 8;
   localparam int unsigned FLAG_W        = 11;

   // Register subtract: fixed low half-word, high half-word bits 15..9 zero.
   localparam logic [15:0] OP_SUB_LSW    = 16'hE720;
   localparam logic [6:0]  SUB_MSW_ZERO  = 7'h00;
   localparam int unsigned SUB_ZERO_LSB  = 9;
   localparam int unsigned SRC_B_LSB     = 6;
   localparam int unsigned SRC_A_LSB     = 3;
   localparam int unsigned DST_LSB       = 0;

   // Flag-carrying opcodes: prefix in low half-word bits 15..6.
   localparam logic [9:0]  OP_SAVE_PFX   = 10'h399;
   localparam logic [9:0]  OP_MASKED_FLAG_SET_OP_PFX = 10'h39E;
   localparam int unsigned PFX_LSB       = 6;
   localparam logic [31:0] OP_RESTORE    = 32'h0000_E620;

   // Select mask = {lsw[5:0], msw[15:11]}, value mask = msw[10:0].
   localparam int unsigned SEL_HI_W      = 6;
   localparam int unsigned SEL_LO_LSB    = 11;

   // Status flag bit positions.
   localparam int unsigned FLG_RND       = 9;
   localparam int unsigned FLG_TF        = 6;
   localparam int unsigned FLG_ZI        = 5;
   localparam int unsigned FLG_NI        = 4;
   localparam int unsigned FLG_ZF        = 3;
   localparam int unsigned FLG_NF        = 2;
   localparam int unsigned FLG_LUF       = 1;
   localparam int unsigned FLG_LVF       = 0;
   localparam logic [10:0] FLG_IMPL      = 11'h27F;

   // Reset values.
   localparam logic [10:0] FLG_RST       = 11'h000;
   localparam logic [31:0] REG_RST       = 32'h0000_0000;

   // Issuer state: free, or one delay slot of a pending subtract.
   typedef enum logic [0:0] {
      ST_FREE = 1'b0,
      ST_SLOT = 1'b1
   } fsu_iss_st_t;

endpackage

// ---- rtl/fsu_if.sv ----
// Instruction path between the issuing pipeline and the floating-point unit.
`timescale 1ns/1ps
interface fsu_if;
   logic        ins_valid;
   logic [31:0] ins_word;

   modport dev (
      input ins_valid,
      input ins_word
   );

   modport host (
      output ins_valid,
      output ins_word
   );
endinterface

// ---- rtl/fsu_dev.sv ----
// Floating-point unit end: register subtract, masked flag set, shadow save and restore.
`timescale 1ns/1ps
module fsu_dev (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Instruction stream
   fsu_if.dev               ins,
   // Register load from the core
   input  wire logic        ld_valid,
   input  wire logic [2:0]  ld_sel,
   input  wire logic [31:0] ld_data,
   // Register readback
   input  wire logic [2:0]  rd_sel,
   output logic      [31:0] rd_data,
   // Status
   output logic      [10:0] fpu_status_flags,
   output logic             sub_busy
);

   // Leading-zero count of the unnormalised sum, used by the stage-two shifter.
   function automatic logic [4:0] lead_zeros(input logic [26:0] v);
      logic [4:0] n;
      logic       seen;
      n = 5'h00;
      seen = 1'b0;
      for (int i = 26; i >= 0; i--) begin
         if (!seen && !v[i]) begin
            n = n + 5'h01;
         end else begin
            seen = 1'b1;
         end
      end
      return n;
   endfunction

   logic [31:0] regs_r   [fsu_pkg::NUM_REGS];
   logic [31:0] shadow_r [fsu_pkg::NUM_REGS];
   logic [10:0] status_r;
   logic [10:0] status_nxt;
   logic [10:0] shadow_flg_r;
   logic [31:0] rd_data_r;

   // Instruction decode.
   wire  [15:0] lsw = ins.ins_word[15:0];
   wire  [15:0] msw = ins.ins_word[31:16];
   wire  [2:0]  dest_reg_sel  = msw[fsu_pkg::DST_LSB +: 3];
   wire  [2:0]  src_a_reg_sel = msw[fsu_pkg::SRC_A_LSB +: 3];
   wire  [2:0]  src_b_reg_sel = msw[fsu_pkg::SRC_B_LSB +: 3];
   wire         is_sub  = ins.ins_valid && lsw == fsu_pkg::OP_SUB_LSW
                          && msw[15:fsu_pkg::SUB_ZERO_LSB] == fsu_pkg::SUB_MSW_ZERO;
   wire         is_flg  = ins.ins_valid
                          && lsw[15:fsu_pkg::PFX_LSB] == fsu_pkg::OP_MASKED_FLAG_SET_OP_PFX;
   wire         is_save = ins.ins_valid
                          && lsw[15:fsu_pkg::PFX_LSB] == fsu_pkg::OP_SAVE_PFX;
   wire         is_rest = ins.ins_valid && ins.ins_word == fsu_pkg::OP_RESTORE;
   wire  [10:0] flg_sel = {lsw[fsu_pkg::SEL_HI_W-1:0], msw[15:fsu_pkg::SEL_LO_LSB]}
                          & fsu_pkg::FLG_IMPL;
   wire  [10:0] flg_val = msw[fsu_pkg::SEL_LO_LSB-1:0];
   wire         flg_upd = is_flg || is_save;

   // Stage one: unpack, flip the sign of the second source, align and add.
   wire  [31:0] op_a   = regs_r[src_a_reg_sel];
   wire  [31:0] op_b   = regs_r[src_b_reg_sel] ^ 32'h8000_0000;
   // Denormal inputs are flushed to zero; it keeps the aligner free of a second path.
   wire  [23:0] man_a  = (op_a[30:23] != 8'h00) ? {1'b1, op_a[22:0]} : 24'h000000;
   wire  [23:0] man_b  = (op_b[30:23] != 8'h00) ? {1'b1, op_b[22:0]} : 24'h000000;
   wire         a_big  = {op_a[30:23], man_a} >= {op_b[30:23], man_b};
   wire         big_s  = a_big ? op_a[31] : op_b[31];
   wire         sml_s  = a_big ? op_b[31] : op_a[31];
   wire  [7:0]  big_e  = a_big ? op_a[30:23] : op_b[30:23];
   wire  [7:0]  sml_e  = a_big ? op_b[30:23] : op_a[30:23];
   wire  [26:0] big_m  = {(a_big ? man_a : man_b), 3'h0};
   wire  [26:0] sml_m  = {(a_big ? man_b : man_a), 3'h0};
   wire  [7:0]  e_diff = big_e - sml_e;
   wire  [26:0] sml_sh = sml_m >> e_diff;
   wire         sticky = (sml_sh << e_diff) != sml_m;
   wire  [26:0] sml_al = {sml_sh[26:1], sml_sh[0] | sticky};
   wire  [27:0] sum    = (big_s ^ sml_s) ? {1'b0, big_m} - {1'b0, sml_al}
                                         : {1'b0, big_m} + {1'b0, sml_al};

   logic        s1_v_r;
   logic [2:0]  s1_dst_r;
   logic        s1_sign_r;
   logic [7:0]  s1_exp_r;
   logic [27:0] s1_sum_r;

   // Stage two: normalise, round by the mode bit, range check.
   wire  [4:0]  lz      = lead_zeros(s1_sum_r[26:0]);
   wire  [26:0] norm    = s1_sum_r[27]
                          ? {s1_sum_r[27:2], s1_sum_r[1] | s1_sum_r[0]}
                          : s1_sum_r[26:0] << lz;
   wire  signed [9:0] ne = $signed({2'b00, s1_exp_r})
                          + (s1_sum_r[27] ? 10'sh001 : 10'sh000)
                          - $signed({5'h00, lz});
   wire         rnd_up  = status_r[fsu_pkg::FLG_RND] && norm[2]
                          && ((|norm[1:0]) || norm[3]);
   wire  [23:0] rnd_man = {1'b0, norm[25:3]} + {23'h000000, rnd_up};
   wire  signed [9:0] re = ne + $signed({9'h000, rnd_man[23]});
   wire         res_zero = s1_sum_r == 28'h0000000;
   wire         res_ovf  = !res_zero && re >= 10'sh0FF;
   wire         res_unf  = !res_zero && re <= 10'sh000;
   // Out-of-range results saturate to signed zero or infinity; no denormal is produced.
   wire  [31:0] res_sz   = {s1_sign_r, 31'h0000_0000};
   wire  [31:0] res_inf  = {s1_sign_r, 8'hFF, 23'h000000};
   wire  [31:0] res_norm = {s1_sign_r, re[7:0], rnd_man[22:0]};
   wire  [31:0] result   = res_zero ? 32'h0000_0000
                         : res_unf  ? res_sz
                         : res_ovf  ? res_inf
                         : res_norm;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_v_r    <= 1'b0;
         s1_dst_r  <= 3'h0;
         s1_sign_r <= 1'b0;
         s1_exp_r  <= 8'h00;
         s1_sum_r  <= 28'h0000000;
      end else begin
         s1_v_r <= is_sub;
         if (is_sub) begin
            s1_dst_r  <= dest_reg_sel;
            s1_sign_r <= big_s;
            s1_exp_r  <= big_e;
            s1_sum_r  <= sum;
         end
      end
   end

   // Status update: subtract latches only the two range flags, flag set overrides.
   always_comb begin
      status_nxt = status_r;
      if (s1_v_r) begin
         status_nxt[fsu_pkg::FLG_LUF] = status_r[fsu_pkg::FLG_LUF] | res_unf;
         status_nxt[fsu_pkg::FLG_LVF] = status_r[fsu_pkg::FLG_LVF] | res_ovf;
      end
      if (flg_upd) begin
         status_nxt = (status_nxt & ~flg_sel) | (flg_val & flg_sel);
      end
      if (is_rest) begin
         status_nxt = shadow_flg_r;
      end
   end

   // Save captures the flags before its own masked update lands.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_r     <= fsu_pkg::FLG_RST;
         shadow_flg_r <= fsu_pkg::FLG_RST;
      end else begin
         status_r <= status_nxt;
         if (is_save) begin
            shadow_flg_r <= status_r;
         end
      end
   end

   // Readback is one cycle late so the data output comes straight from a flop.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_r <= fsu_pkg::REG_RST;
      end else begin
         rd_data_r <= regs_r[rd_sel];
      end
   end

   // One write port per register. The issuer keeps restore and subtract write-back apart,
   // but loads bypass it; restore wins, then subtract write-back, then load.
   for (genvar g = 0; g < fsu_pkg::NUM_REGS; g++) begin : g_reg
      wire [2:0] reg_idx = 3'(g);
      wire       sub_wr  = s1_v_r && s1_dst_r == reg_idx;
      wire       ld_wr   = ld_valid && ld_sel == reg_idx;

      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            regs_r[g]   <= fsu_pkg::REG_RST;
            shadow_r[g] <= fsu_pkg::REG_RST;
         end else begin
            if (is_rest) begin
               regs_r[g] <= shadow_r[g];
            end else if (sub_wr) begin
               regs_r[g] <= result;
            end else if (ld_wr) begin
               regs_r[g] <= ld_data;
            end
            if (is_save) begin
               shadow_r[g] <= regs_r[g];
            end
         end
      end
   end

   assign rd_data          = rd_data_r;
   assign fpu_status_flags = status_r;
   assign sub_busy         = s1_v_r;

endmodule

// ---- rtl/fsu_host.sv ----
// Issuing end: registers instructions onto the unit and holds back delay-slot conflicts.
`timescale 1ns/1ps
module fsu_host (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Instruction stream to the unit
   fsu_if.host              ins,
   // Command port from the core pipeline
   input  wire logic        cmd_valid,
   input  wire logic [31:0] cmd_word,
   input  wire logic [7:0]  cmd_uses,
   output logic             cmd_ready
);

   fsu_pkg::fsu_iss_st_t state_r;
   fsu_pkg::fsu_iss_st_t state_nxt;
   logic [2:0]           pend_dst_r;
   logic                 ins_valid_r;
   logic [31:0]          ins_word_r;

   wire  [15:0] c_lsw    = cmd_word[15:0];
   wire  [15:0] c_msw    = cmd_word[31:16];
   wire  [2:0]  c_dst    = c_msw[fsu_pkg::DST_LSB +: 3];
   wire         c_sub    = c_lsw == fsu_pkg::OP_SUB_LSW
                           && c_msw[15:fsu_pkg::SUB_ZERO_LSB] == fsu_pkg::SUB_MSW_ZERO;
   wire         c_ctl    = c_lsw[15:fsu_pkg::PFX_LSB] == fsu_pkg::OP_SAVE_PFX
                           || c_lsw[15:fsu_pkg::PFX_LSB] == fsu_pkg::OP_MASKED_FLAG_SET_OP_PFX
                           || cmd_word == fsu_pkg::OP_RESTORE;
   // A subtract names its own registers; any other instruction declares them.
   wire  [7:0]  sub_uses = (8'h01 << c_dst)
                           | (8'h01 << c_msw[fsu_pkg::SRC_A_LSB +: 3])
                           | (8'h01 << c_msw[fsu_pkg::SRC_B_LSB +: 3]);
   wire  [7:0]  uses     = c_sub ? sub_uses : cmd_uses;
   wire         in_slot  = state_r == fsu_pkg::ST_SLOT;
   wire         hazard   = in_slot && (c_ctl || uses[pend_dst_r]);
   wire         take     = cmd_valid && !hazard;

   // A refused command leaves a bubble in the slot, which acts as the padding no-op.
   always_comb begin
      case (state_r)
         fsu_pkg::ST_FREE: state_nxt = (take && c_sub) ? fsu_pkg::ST_SLOT : fsu_pkg::ST_FREE;
         fsu_pkg::ST_SLOT: state_nxt = (take && c_sub) ? fsu_pkg::ST_SLOT : fsu_pkg::ST_FREE;
         default:          state_nxt = fsu_pkg::ST_FREE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r     <= fsu_pkg::ST_FREE;
         pend_dst_r  <= 3'h0;
         ins_valid_r <= 1'b0;
         ins_word_r  <= 32'h0000_0000;
      end else begin
         state_r     <= state_nxt;
         ins_valid_r <= take;
         if (take) begin
            ins_word_r <= cmd_word;
            pend_dst_r <= c_dst;
         end
      end
   end

   assign cmd_ready     = !hazard;
   assign ins.ins_valid = ins_valid_r;
   assign ins.ins_word  = ins_word_r;

endmodule

// ---- tb/fsu_link_assertions.sv ----
// Timing and hazard checks on the issuer-to-unit link.
`timescale 1ns/1ps
module fsu_link_assertions (
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Link and end ports
   input wire logic        ins_valid,
   input wire logic [31:0] ins_word,
   input wire logic        cmd_valid,
   input wire logic [31:0] cmd_word,
   input wire logic        cmd_ready,
   input wire logic        sub_busy,
   input wire logic [10:0] fpu_status_flags
);
   wire [9:0]  pfx    = ins_word[15:6];
   wire        is_sub = ins_valid && ins_word[15:0] == fsu_pkg::OP_SUB_LSW
                        && ins_word[31:25] == 7'h00;
   wire        is_flg = ins_valid && (pfx == fsu_pkg::OP_SAVE_PFX
                        || pfx == fsu_pkg::OP_MASKED_FLAG_SET_OP_PFX);
   wire        is_rst = ins_valid && ins_word == fsu_pkg::OP_RESTORE;
   wire [10:0] sel    = {ins_word[5:0], ins_word[31:27]};
   wire [10:0] val    = ins_word[26:16];
   wire [2:0]  dst    = ins_word[18:16];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // A subtract followed by a slot that leaves the flags alone.
   sequence s_sub_quiet_slot;
      is_sub ##1 (!is_flg && !is_rst);
   endsequence
   sequence s_sub_then_sub;
      is_sub ##1 is_sub;
   endsequence

   AST_BUSY_AFTER_SUB: assert property (is_sub |=> sub_busy)
      else $error("second stage missing after subtract");
   AST_BUSY_CAUSE: assert property (sub_busy |-> $past(is_sub))
      else $error("second stage without subtract");
   AST_SLOT_NO_FLAG: assert property (sub_busy |-> !is_flg && !is_rst)
      else $error("flag or shadow operation in delay slot");
   AST_SLOT_NO_DEST: assert property (s_sub_then_sub |-> ins_word[18:16] != $past(dst)
      && ins_word[21:19] != $past(dst) && ins_word[24:22] != $past(dst))
      else $error("delay slot touches pending destination");
   AST_TAKE_FWD: assert property (cmd_valid && cmd_ready |=> ins_valid
      && ins_word == $past(cmd_word))
      else $error("taken command not forwarded");
   AST_REFUSE_BUBBLE: assert property (cmd_valid && !cmd_ready |=> !ins_valid)
      else $error("refusal did not leave a bubble");
   AST_REFUSE_ONCE: assert property (!cmd_ready |=> cmd_ready)
      else $error("refusal longer than one cycle");
   AST_FLAG_UPDATE: assert property (is_flg |=> fpu_status_flags ==
      ((($past(fpu_status_flags) & ~$past(sel)) | ($past(val) & $past(sel)))
      & fsu_pkg::FLG_IMPL))
      else $error("masked flag update wrong");
   AST_SUB_FLAGS: assert property (s_sub_quiet_slot |=>
      fpu_status_flags[10:2] == $past(fpu_status_flags[10:2])
      && ($past(fpu_status_flags[1:0]) & ~fpu_status_flags[1:0]) == 2'h0)
      else $error("subtract disturbed other flags");
endmodule

// ---- tb/test_fpu_flag_save_and_subtract.sv ----
// Self-checking bench with the issuer and the unit joined back to back.
`timescale 1ns/1ps
module test_fpu_flag_save_and_subtract;
   typedef struct {
      logic [2:0]  a, b, d;
      logic [31:0] va, vb, ex;
      logic [10:0] ef;
   } fsu_row_t;
   logic        clk       = 1'b0;
   logic        rst_n     = 1'b0;
   logic        cmd_valid = 1'b0;
   logic [31:0] cmd_word  = 32'h0000_0000;
   logic [7:0]  cmd_uses  = 8'h00;
   logic        ld_valid  = 1'b0;
   logic [2:0]  ld_sel    = 3'h0;
   logic [31:0] ld_data   = 32'h0000_0000;
   logic [2:0]  rd_sel    = 3'h0;
   logic        cmd_ready;
   logic [31:0] rd_data;
   logic [10:0] fpu_status_flags;
   logic        sub_busy;
   logic [10:0] ef;
   int          tries;
   int          num_errors  = 0;
   int          check_count = 0;
   // Flags are sticky, so each row expects its own flags and those of all rows before it.
   fsu_row_t    rows [5] = '{
      '{3'h0, 3'h1, 3'h2, 32'h4040_0000, 32'h3F80_0000, 32'h4000_0000, 11'h000},
      '{3'h1, 3'h0, 3'h5, 32'h3F80_0000, 32'h4040_0000, 32'hC000_0000, 11'h000},
      '{3'h3, 3'h4, 3'h5, 32'h7F7F_FFFF, 32'hFF7F_FFFF, 32'h7F80_0000, 11'h001},
      '{3'h6, 3'h7, 3'h0, 32'h0080_0001, 32'h0080_0000, 32'h0000_0000, 11'h003},
      '{3'h1, 3'h1, 3'h4, 32'h3F80_0000, 32'h3F80_0000, 32'h0000_0000, 11'h003}};

   fsu_if i_fsu_if ();
   fsu_host i_fsu_host (.clk(clk), .rst_n(rst_n), .ins(i_fsu_if), .cmd_valid(cmd_valid),
      .cmd_word(cmd_word), .cmd_uses(cmd_uses), .cmd_ready(cmd_ready));
   fsu_dev i_fsu_dev (.clk(clk), .rst_n(rst_n), .ins(i_fsu_if), .ld_valid(ld_valid),
      .ld_sel(ld_sel), .ld_data(ld_data), .rd_sel(rd_sel), .rd_data(rd_data),
      .fpu_status_flags(fpu_status_flags), .sub_busy(sub_busy));
   fsu_link_assertions i_fsu_link_assertions (.clk(clk), .rst_n(rst_n),
      .ins_valid(i_fsu_if.ins_valid), .ins_word(i_fsu_if.ins_word), .cmd_valid(cmd_valid),
      .cmd_word(cmd_word), .cmd_ready(cmd_ready), .sub_busy(sub_busy),
      .fpu_status_flags(fpu_status_flags));

   always #2 clk = ~clk;

   function automatic logic [31:0] sw(input logic [2:0] a, b, d);
      return {7'h00, b, a, d, fsu_pkg::OP_SUB_LSW};
   endfunction
   function automatic logic [31:0] fw(input logic [9:0] p, input logic [10:0] s, v);
      return {s[4:0], v, p, s[10:5]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Starts at a falling edge and leaves the request up, so calls may run back to back.
   task automatic issue(input logic [31:0] w, input logic [7:0] u);
      logic took;
      took = 1'b0;
      cmd_valid = 1'b1;
      cmd_word = w;
      cmd_uses = u;
      for (tries = 0; tries < 4 && !took; tries++) begin
         #1;
         took = (cmd_ready === 1'b1);
         @(negedge clk);
      end
      if (!took) begin
         num_errors++;
         $display("MISMATCH %0t command never taken", $time);
         end_sim();
      end
   endtask
   task automatic ld(input logic [2:0] s, input logic [31:0] v);
      @(negedge clk);
      ld_valid = 1'b1;
      ld_sel = s;
      ld_data = v;
      @(negedge clk);
      ld_valid = 1'b0;
   endtask
   task automatic settle(input logic [2:0] s);
      cmd_valid = 1'b0;
      @(negedge clk);
      rd_sel = s;
      repeat (3) @(negedge clk);
   endtask

   initial begin
      repeat (16) @(negedge clk);
      check(32'(fpu_status_flags), 32'(fsu_pkg::FLG_RST));
      check(rd_data, fsu_pkg::REG_RST);
      check({sub_busy, cmd_ready}, 32'h0000_0001);
      rst_n = 1'b1;
      foreach (rows[i]) begin
         ld(rows[i].a, rows[i].va);
         ld(rows[i].b, rows[i].vb);
         issue(sw(rows[i].a, rows[i].b, rows[i].d), 8'h00);
         settle(rows[i].d);
         check(rd_data, rows[i].ex);
         check(32'(fpu_status_flags), 32'(rows[i].ef));
      end
      issue(sw(3'h0, 3'h1, 3'h2), 8'h00);
      issue(fw(fsu_pkg::OP_MASKED_FLAG_SET_OP_PFX, 11'h7FF, 11'h7FF), 8'h00);
      check(32'(tries), 32'h0000_0002);
      settle(3'h2);
      ef = fsu_pkg::FLG_IMPL;
      check(32'(fpu_status_flags), 32'(ef));
      for (int i = 0; i < 11; i++) begin
         issue(fw(fsu_pkg::OP_MASKED_FLAG_SET_OP_PFX, 11'h001 << i, 11'h000), 8'h00);
         settle(3'h0);
         ef = ef & ~(11'h001 << i);
         check(32'(fpu_status_flags), 32'(ef));
      end
      issue(sw(3'h0, 3'h1, 3'h3), 8'h00);
      issue(sw(3'h0, 3'h1, 3'h4), 8'h00);
      check(32'(tries), 32'h0000_0001);
      issue(32'h0000_0000, 8'h10);
      check(32'(tries), 32'h0000_0002);
      settle(3'h3);
      check(rd_data, 32'hBF80_0000);
      issue(fw(fsu_pkg::OP_SAVE_PFX, 11'h200, 11'h200), 8'h00);
      settle(3'h4);
      check(rd_data, 32'hBF80_0000);
      check(32'(fpu_status_flags), 32'h0000_0200);
      ld(3'h3, 32'h1234_5678);
      issue(fsu_pkg::OP_RESTORE, 8'h00);
      settle(3'h3);
      check(rd_data, 32'hBF80_0000);
      check(32'(fpu_status_flags), 32'h0000_0000);
      issue(sw(3'h0, 3'h1, 3'h2), 8'h00);
      issue(fw(fsu_pkg::OP_SAVE_PFX, 11'h000, 11'h000), 8'h00);
      check(32'(tries), 32'h0000_0002);
      issue(sw(3'h0, 3'h1, 3'h2), 8'h00);
      issue(fsu_pkg::OP_RESTORE, 8'h00);
      check(32'(tries), 32'h0000_0002);
      settle(3'h2);
      check(rd_data, 32'hBF80_0000);
      // A tie at half a unit in the last place: truncation keeps it, nearest-even rounds up.
      ld(3'h5, 32'h3F80_0000);
      ld(3'h6, 32'h3300_0000);
      issue(sw(3'h5, 3'h6, 3'h7), 8'h00);
      settle(3'h7);
      check(rd_data, 32'h3F7F_FFFF);
      issue(fw(fsu_pkg::OP_MASKED_FLAG_SET_OP_PFX, 11'h200, 11'h200), 8'h00);
      issue(sw(3'h5, 3'h6, 3'h7), 8'h00);
      settle(3'h7);
      check(rd_data, 32'h3F80_0000);
      check(32'(fpu_status_flags), 32'h0000_0200);
      // Reset in mid-run clears registers and flags and leaves the issuer idle.
      rst_n = 1'b0;
      @(negedge clk);
      check(32'(fpu_status_flags), 32'(fsu_pkg::FLG_RST));
      check(rd_data, fsu_pkg::REG_RST);
      check({sub_busy, cmd_ready}, 32'h0000_0001);
      rst_n = 1'b1;
      settle(3'h5);
      check(rd_data, fsu_pkg::REG_RST);
      end_sim();
   end
endmodule
